/* File: rtl/dual_clock_fifo_status_flags.v */
// deep fifo with write/read side strobes, status flags and retransmit
`include "fifo_flags_defines.vh"

module dual_clock_fifo_status_flags #(
  parameter AW = `DEF_DEPTH_LOG2,
  parameter DW = `DATA_W
) (
  input wire i_ref_clk,
  input wire i_rst_b,
  input wire i_wr_clk,
  input wire i_rd_clk,
  input wire i_master_reset_n,
  input wire i_partial_reset_n,
  input wire i_write_enable_n,
  input wire i_read_enable_n,
  input wire i_retransmit_n,
  input wire i_first_word_fall_through,
  input wire i_flag_timing_select,
  input wire i_retransmit_latency_select,
  input wire [1:0] i_out_width,
  input wire [DW-1:0] i_data_in,
  input wire [AW-1:0] i_empty_offset,
  input wire [AW-1:0] i_full_offset,
  output wire [DW-1:0] o_read_data_out,
  output wire o_full_flag_n,
  output wire o_empty_flag_n,
  output wire o_half_full_n,
  output wire o_almost_full_n,
  output wire o_almost_empty_n
);

  localparam PW = AW + 2;
  localparam PINW = `CTRL_W + DW + 2 * AW;
  localparam [PINW-1:0] PIN_RST = {`CTRL_RST, {(PINW-`CTRL_W){1'b0}}};
  localparam [PW-1:0] ONE = {{(PW-1){1'b0}}, 1'b1};
  localparam [PW-1:0] DEPTH_W = {2'b01, {AW{1'b0}}};
  localparam [PW-1:0] HALF_W = {3'b001, {(AW-1){1'b0}}};
  localparam MEM_WORDS = 1 << AW;
  // storage array
  reg [DW-1:0] mem [0:MEM_WORDS-1];
  // latched modes
  reg first_word_fall_through_r;
  reg pfm_r;
  reg rm_r;
  reg [1:0] width_r;
  // write side state
  reg wclk_d_r;
  reg [PW-1:0] wptr_r;
  reg [PW-1:0] wgray_r;
  reg full_r;
  reg ffir_r;
  // read side state
  reg rclk_d_r;
  reg [PW-1:0] rptr_r;
  reg [PW-1:0] cgray_r;
  reg ov_r;
  reg ne_r;
  reg efor_r;
  reg [DW-1:0] q_r;
  // flags touched by both sides
  reg hf_r;
  reg paf_r;
  reg pae_r;
  // every pin except i_ref_clk and i_rst_b passes two flops before use
  wire [PINW-1:0] pin_s;
  sync2 #(
    .W(PINW),
    .RST_VAL(PIN_RST)
  ) u_pin_sync (
    .i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .i_d({i_master_reset_n, i_partial_reset_n, i_write_enable_n, i_read_enable_n,
          i_retransmit_n, i_wr_clk, i_rd_clk, i_first_word_fall_through,
          i_flag_timing_select, i_retransmit_latency_select, i_out_width,
          i_data_in, i_empty_offset, i_full_offset}),
    .o_q(pin_s)
  );

  wire mrs_s;
  wire prs_s;
  wire wen_s;
  wire ren_s;
  wire rt_s;
  wire wclk_s;
  wire rclk_s;
  wire first_word_fall_through_s;
  wire pfm_s;
  wire rm_s;
  wire [1:0] width_s;
  wire [DW-1:0] data_s;
  wire [AW-1:0] eoff_s;
  wire [AW-1:0] foff_s;
  // unpack the synchronised pin bundle
  assign {mrs_s, prs_s, wen_s, ren_s, rt_s, wclk_s, rclk_s, first_word_fall_through_s, pfm_s, rm_s,
          width_s, data_s, eoff_s, foff_s} = pin_s;

  // gray pointers cross between the two sides
  wire [PW-1:0] cgray_s;
  wire [PW-1:0] wgray_s;
  sync2 #(
    .W(PW),
    .RST_VAL({PW{1'b0}})
  ) u_rd_to_wr (
    .i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .i_d(cgray_r),
    .o_q(cgray_s)
  );
  sync2 #(
    .W(PW),
    .RST_VAL({PW{1'b0}})
  ) u_wr_to_rd (
    .i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .i_d(wgray_r),
    .o_q(wgray_s)
  );

  function [PW-1:0] bin2gray;
    input [PW-1:0] b;
    begin
      bin2gray = b ^ (b >> 1);
    end
  endfunction

  function [PW-1:0] gray2bin;
    input [PW-1:0] g;
    integer k;
    begin
      gray2bin[PW-1] = g[PW-1];
      for (k = PW - 2; k >= 0; k = k - 1) begin
        gray2bin[k] = gray2bin[k+1] ^ g[k];
      end
    end
  endfunction

  // rising edges of the side strobes, seen on the reference clock
  wire w_edge = wclk_s & ~wclk_d_r;
  wire r_edge = rclk_s & ~rclk_d_r;
  wire in_reset = ~mrs_s | ~prs_s;

  // thresholds from depth and timing mode
  wire [PW-1:0] first_word_fall_through_pw = {{(PW-1){1'b0}}, first_word_fall_through_r};
  wire [PW-1:0] cap = DEPTH_W + first_word_fall_through_pw;
  wire [PW-1:0] hf_thr = HALF_W + first_word_fall_through_pw;
  wire [PW-1:0] ae_thr = {2'b00, eoff_s} + first_word_fall_through_pw;
  wire [PW-1:0] af_thr = cap - {2'b00, foff_s};

  // write side: count against the synchronised consumed pointer
  wire [PW-1:0] rsync_bin = gray2bin(cgray_s);
  wire w_do = w_edge & ~wen_s & ~full_r & ~in_reset;
  wire [PW-1:0] wptr_nxt = w_do ? wptr_r + ONE : wptr_r;
  wire [PW-1:0] wcnt_nxt = wptr_nxt - rsync_bin;
  wire full_nxt = (wcnt_nxt >= cap);

  // read side decisions
  wire [PW-1:0] wsync_bin = gray2bin(wgray_s);
  wire rt_hit = r_edge & ~rt_s & ~in_reset;
  wire std_rd = r_edge & ~ren_s & ne_r & ~first_word_fall_through_r;
  wire consume = r_edge & ~ren_s & ov_r & first_word_fall_through_r;
  wire fetch = r_edge & ne_r & first_word_fall_through_r & (~ov_r | consume);
  reg [PW-1:0] rptr_nxt;
  reg ov_nxt;
  reg ld_q;
  reg [AW-1:0] q_addr;
  // next read pointer, output word and load decision
  always @* begin
    rptr_nxt = rptr_r;
    ov_nxt = ov_r;
    ld_q = 1'b0;
    q_addr = rptr_r[AW-1:0];
    if (rt_hit) begin
      if (rm_r) begin
        // normal latency: rewind, flags drop and recover on later edges
        rptr_nxt = {PW{1'b0}};
        ov_nxt = 1'b0;
      end else begin
        // zero latency: first word presented on this same edge
        rptr_nxt = ONE;
        ov_nxt = first_word_fall_through_r;
        ld_q = 1'b1;
        q_addr = {AW{1'b0}};
      end
    end else if (first_word_fall_through_r) begin
      if (fetch) begin
        rptr_nxt = rptr_r + ONE;
        ov_nxt = 1'b1;
        ld_q = 1'b1;
      end else if (consume) begin
        ov_nxt = 1'b0;
      end
    end else if (std_rd) begin
      rptr_nxt = rptr_r + ONE;
      ld_q = 1'b1;
    end
  end

  // memory not empty, consumed pointer and total count on the read side
  wire ne_nxt = (rt_hit & rm_r) ? 1'b0 : (wsync_bin != rptr_nxt);
  wire [PW-1:0] cons_nxt = rptr_nxt - {{(PW-1){1'b0}}, ov_nxt};
  wire [PW-1:0] rcnt_nxt = wsync_bin - cons_nxt;
  wire efor_nxt = first_word_fall_through_r ? ~ov_nxt : ne_nxt;
  reg [DW-1:0] lane_mask;
  // lane selection for the output bus width
  always @* begin
    case (width_r)
      `OUT_W36: lane_mask = `LANE36_MASK;
      `OUT_W18: lane_mask = `LANE18_MASK;
      `OUT_W9: lane_mask = `LANE9_MASK;
      default: lane_mask = `LANE36_MASK;
    endcase
  end

  // storage write, no reset needed
  always @(posedge i_ref_clk) begin
    if (w_do) begin
      mem[wptr_r[AW-1:0]] <= data_s;
    end
  end

  // edge history of the side strobes
  always @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      wclk_d_r <= 1'b0;
      rclk_d_r <= 1'b0;
    end else begin
      wclk_d_r <= wclk_s;
      rclk_d_r <= rclk_s;
    end
  end

  wire mode_first_word_fall_through = mrs_s ? first_word_fall_through_r : first_word_fall_through_s;
  // modes, pointers, output word and pointer-driven flags
  always @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      first_word_fall_through_r <= 1'b0;
      pfm_r <= 1'b0;
      rm_r <= 1'b0;
      width_r <= `OUT_W36;
      wptr_r <= {PW{1'b0}};
      wgray_r <= {PW{1'b0}};
      full_r <= 1'b0;
      ffir_r <= 1'b1;
      rptr_r <= {PW{1'b0}};
      cgray_r <= {PW{1'b0}};
      ov_r <= 1'b0;
      ne_r <= 1'b0;
      efor_r <= 1'b0;
      q_r <= {DW{1'b0}};
    end else if (in_reset) begin
      if (!mrs_s) begin
        // straps caught while master reset is held
        first_word_fall_through_r <= first_word_fall_through_s;
        pfm_r <= pfm_s;
        rm_r <= rm_s;
        width_r <= width_s;
      end
      wptr_r <= {PW{1'b0}};
      wgray_r <= {PW{1'b0}};
      full_r <= 1'b0;
      ffir_r <= ~mode_first_word_fall_through;
      rptr_r <= {PW{1'b0}};
      cgray_r <= {PW{1'b0}};
      ov_r <= 1'b0;
      ne_r <= 1'b0;
      efor_r <= mode_first_word_fall_through;
      q_r <= {DW{1'b0}};
    end else begin
      if (w_edge) begin
        wptr_r <= wptr_nxt;
        wgray_r <= bin2gray(wptr_nxt);
        full_r <= full_nxt;
        ffir_r <= first_word_fall_through_r ? full_nxt : ~full_nxt;
      end
      if (r_edge) begin
        rptr_r <= rptr_nxt;
        ov_r <= ov_nxt;
        ne_r <= ne_nxt;
        cgray_r <= bin2gray(cons_nxt);
        efor_r <= efor_nxt;
      end
      if (ld_q) begin
        q_r <= mem[q_addr] & lane_mask;
      end
    end
  end

  // half-full: set by writes, cleared by reads
  always @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      hf_r <= `HALF_FULL_RST;
    end else if (in_reset) begin
      hf_r <= `HALF_FULL_RST;
    end else if (w_edge && (wcnt_nxt > hf_thr)) begin
      hf_r <= 1'b0;
    end else if (r_edge && (rcnt_nxt <= hf_thr)) begin
      hf_r <= 1'b1;
    end
  end

  // almost-full: write edges only when synchronous, else split edges
  always @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      paf_r <= `ALMOST_FULL_RST;
    end else if (in_reset) begin
      paf_r <= `ALMOST_FULL_RST;
    end else if (pfm_r) begin
      if (w_edge) begin
        paf_r <= ~(wcnt_nxt >= af_thr);
      end
    end else if (w_edge && (wcnt_nxt >= af_thr)) begin
      paf_r <= 1'b0;
    end else if (r_edge && (rcnt_nxt < af_thr)) begin
      paf_r <= 1'b1;
    end
  end

  // almost-empty: read edges only when synchronous, else split edges
  always @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      pae_r <= `ALMOST_EMPTY_RST;
    end else if (in_reset) begin
      pae_r <= `ALMOST_EMPTY_RST;
    end else if (pfm_r) begin
      if (r_edge) begin
        pae_r <= ~(rcnt_nxt <= ae_thr);
      end
    end else if (r_edge && (rcnt_nxt <= ae_thr)) begin
      pae_r <= 1'b0;
    end else if (w_edge && (wcnt_nxt > ae_thr)) begin
      pae_r <= 1'b1;
    end
  end

  // outputs straight from flops
  assign o_read_data_out = q_r;
  assign o_full_flag_n = ffir_r;
  assign o_empty_flag_n = efor_r;
  assign o_half_full_n = hf_r;
  assign o_almost_full_n = paf_r;
  assign o_almost_empty_n = pae_r;

endmodule

/* File: rtl/fifo_flags_defines.vh */
// shared constants for the dual-clock fifo flag logic
`ifndef FIFO_FLAGS_DEFINES_VH
`define FIFO_FLAGS_DEFINES_VH

// build defaults
`define DEF_DEPTH_LOG2 16
`define DATA_W 36

// output bus width codes
`define OUT_W36 2'h0
`define OUT_W18 2'h1
`define OUT_W9 2'h2

// lane masks for the output bus widths
`define LANE36_MASK 36'hFFFFFFFFF
`define LANE18_MASK 36'h00003FFFF
`define LANE9_MASK 36'h0000001FF

// control pin bundle: width and idle value (active-low pins idle high)
`define CTRL_W 12
`define CTRL_RST 12'hF80

// flag values after reset
`define HALF_FULL_RST 1'b1
`define ALMOST_FULL_RST 1'b1
`define ALMOST_EMPTY_RST 1'b0

`endif

/* File: rtl/sync2.v */
// two-stage synchroniser for a bundle of bits
module sync2 #(
  parameter W = 1,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
  input wire i_ref_clk,
  input wire i_rst_b,
  input wire [W-1:0] i_d,
  output wire [W-1:0] o_q
);

  reg [W-1:0] meta_r;
  reg [W-1:0] sync_r;

  // first stage feeds only the second stage
  always @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      meta_r <= RST_VAL;
      sync_r <= RST_VAL;
    end else begin
      meta_r <= i_d;
      sync_r <= meta_r;
    end
  end

  assign o_q = sync_r;

endmodule

/* File: tb/fifo_flags_chk_asserts.sv */
// port-level timing checks for the fifo flags
module fifo_flags_chk (
  input wire i_ref_clk,
  input wire i_rst_b,
  input wire i_wr_clk,
  input wire i_rd_clk,
  input wire i_master_reset_n,
  input wire i_partial_reset_n,
  input wire i_flag_timing_select,
  input wire [1:0] i_out_width,
  input wire [35:0] o_read_data_out,
  input wire o_full_flag_n,
  input wire o_empty_flag_n,
  input wire o_half_full_n,
  input wire o_almost_full_n,
  input wire o_almost_empty_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic wp_r, rp_r, pfm_r;
  logic [3:0] wa_r, ra_r, za_r;
  logic [1:0] ow_r;
  wire wn = wa_r >= 4'h1 && wa_r <= 4'h5;
  wire rn = ra_r >= 4'h1 && ra_r <= 4'h5;
  wire zn = za_r <= 4'h5;
  // ages since each pin edge and since any reset; modes latched like the block
  always_ff @(posedge i_ref_clk) begin
    wp_r <= i_wr_clk;
    rp_r <= i_rd_clk;
    wa_r <= !i_rst_b ? 4'hF : (i_wr_clk && !wp_r) ? 4'h0 : (wa_r == 4'hF ? wa_r : wa_r + 4'h1);
    ra_r <= !i_rst_b ? 4'hF : (i_rd_clk && !rp_r) ? 4'h0 : (ra_r == 4'hF ? ra_r : ra_r + 4'h1);
    za_r <= (!i_rst_b || !i_master_reset_n || !i_partial_reset_n) ? 4'h0 :
            (za_r == 4'hF ? za_r : za_r + 4'h1);
    if (!i_master_reset_n) begin
      pfm_r <= i_flag_timing_select;
      ow_r <= i_out_width;
    end
  end
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  a_half_fall_wr: assert property ($fell(o_half_full_n) |-> wn) else $error("half flag fell off a write edge");
  a_half_rise_rd: assert property ($rose(o_half_full_n) |-> rn || zn) else $error("half flag rose off a read edge");
  a_full_clear_wr: assert property ($rose(o_full_flag_n) |-> wn || zn) else $error("full cleared off a write edge");
  a_empty_clear_rd: assert property ($rose(o_empty_flag_n) |-> rn || zn) else $error("empty cleared off a read edge");
  a_af_sync_wr: assert property (pfm_r && $changed(o_almost_full_n) |-> wn || zn)
    else $error("sync almost-full moved off a write edge");
  a_ae_sync_rd: assert property (pfm_r && $changed(o_almost_empty_n) |-> rn || zn)
    else $error("sync almost-empty moved off a read edge");
  a_af_async_edges: assert property (!pfm_r && $changed(o_almost_full_n) |-> ($rose(o_almost_full_n) ? rn : wn) || zn)
    else $error("async almost-full on wrong edge");
  a_ae_async_edges: assert property (!pfm_r && $changed(o_almost_empty_n) |-> ($fell(o_almost_empty_n) ? rn : wn) || zn)
    else $error("async almost-empty on wrong edge");
  a_data_nine_lanes: assert property (ow_r == 2'h2 && !zn |-> o_read_data_out[35:9] == 27'h0)
    else $error("upper lanes set in 9 bit width");
  a_data_rd_edge: assert property ($changed(o_read_data_out) |-> rn || zn) else $error("data moved off a read edge");
endmodule
bind dual_clock_fifo_status_flags fifo_flags_chk i_fifo_flags_chk (.*);

/* File: tb/fifo_peer.sv */
// producer and consumer pins on the far side of the fifo
module fifo_peer (
  input wire i_ref_clk,
  output logic o_wr_clk = 1'b0,
  output logic o_rd_clk = 1'b0,
  output logic o_wen_n = 1'b1,
  output logic o_ren_n = 1'b1,
  output logic o_rt_n = 1'b1,
  output logic [35:0] o_data = 36'h0
);
  timeunit 1ns;
  timeprecision 1ns;
  // one write clock period; clock stands still between calls
  task automatic wr(input bit en, input logic [35:0] d);
    o_wen_n <= !en;
    o_data <= d;
    o_wr_clk <= 1'b1;
    repeat (4) @(posedge i_ref_clk);
    o_wr_clk <= 1'b0;
    o_wen_n <= 1'b1;
    o_data <= ~d; // released lines stop showing the word
    repeat (4) @(posedge i_ref_clk);
  endtask
  // one read clock period, optionally a read or a retransmit
  task automatic rd(input bit en, input bit rt);
    o_ren_n <= !en;
    o_rt_n <= !rt;
    o_rd_clk <= 1'b1;
    repeat (4) @(posedge i_ref_clk);
    o_rd_clk <= 1'b0;
    o_ren_n <= 1'b1;
    o_rt_n <= 1'b1;
    repeat (4) @(posedge i_ref_clk);
  endtask
endmodule

/* File: tb/testbench.sv */
// self-checking bench for the fifo flag block
`include "fifo_flags_defines.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_ref_clk = 1'b0, i_rst_b = 1'b0, i_master_reset_n = 1'b1, i_partial_reset_n = 1'b1;
  logic i_first_word_fall_through = 1'b0, i_flag_timing_select = 1'b0, i_retransmit_latency_select = 1'b0;
  logic [1:0] i_out_width = 2'h0;
  logic [3:0] i_empty_offset = 4'h0, i_full_offset = 4'h0;
  wire i_wr_clk, i_rd_clk, i_write_enable_n, i_read_enable_n, i_retransmit_n;
  wire [35:0] i_data_in, o_read_data_out;
  wire o_full_flag_n, o_empty_flag_n, o_half_full_n, o_almost_full_n, o_almost_empty_n;
  int err_total = 0, total_checks = 0, cap = 16;
  logic [35:0] q[$], sv[$];
  logic [1:0] wl[3] = '{`OUT_W36, `OUT_W18, `OUT_W9};
  logic [35:0] mk[3] = '{`LANE36_MASK, `LANE18_MASK, `LANE9_MASK};
  dual_clock_fifo_status_flags #(.AW(4)) i_dual_clock_fifo_status_flags (.*);
  fifo_peer peer (.i_ref_clk(i_ref_clk), .o_wr_clk(i_wr_clk), .o_rd_clk(i_rd_clk), .o_wen_n(i_write_enable_n),
    .o_ren_n(i_read_enable_n), .o_rt_n(i_retransmit_n), .o_data(i_data_in));
  // clock and watchdog
  initial forever #50 i_ref_clk = ~i_ref_clk;
  initial begin
    #2000000;
    err_total++;
    results();
  end
  task chk(input logic [35:0] s, input logic [35:0] e);
    total_checks++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task results;
    if (err_total == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // master reset with straps held through the release
  task mr(input bit flag_timing_select, input bit rm, input logic [1:0] w, input logic [3:0] n, input logic [3:0] m);
    i_flag_timing_select <= flag_timing_select;
    i_retransmit_latency_select <= rm;
    i_out_width <= w;
    i_empty_offset <= n;
    i_full_offset <= m;
    i_master_reset_n <= 1'b0;
    repeat (5) @(posedge i_ref_clk);
    i_master_reset_n <= 1'b1;
    repeat (5) @(posedge i_ref_clk);
    q.delete();
  endtask
  task put(input int k);
    logic [35:0] d;
    repeat (k) begin
      d = 36'({$urandom(), $urandom()});
      if (q.size() < cap) q.push_back(d); // writes into a full fifo are dropped
      peer.wr(1'b1, d);
    end
  endtask
  task get(input logic [35:0] m);
    for (int i = 0; i < 4 && o_empty_flag_n !== 1'b1; i++) peer.rd(1'b0, 1'b0);
    peer.rd(1'b1, 1'b0);
    chk(o_read_data_out, q.pop_front() & m);
  endtask
  // fall-through read: wait for output ready, check the standing word, then consume it
  task fget(input logic [35:0] m);
    for (int i = 0; i < 4 && o_empty_flag_n !== 1'b0; i++) peer.rd(1'b0, 1'b0);
    chk(o_empty_flag_n, 1'b0);
    chk(o_read_data_out, q.pop_front() & m);
    peer.rd(1'b1, 1'b0);
  endtask
  initial begin
    void'($urandom(32'h19AE));
    repeat (2) @(posedge i_ref_clk);
    i_rst_b <= 1'b1;
    @(posedge i_ref_clk);
    // every output width, empty and almost-empty around a few words
    foreach (wl[i]) begin
      mr(1'b1, 1'b1, wl[i], 4'h2, 4'h2);
      put(3);
      peer.rd(1'b0, 1'b0);
      chk(o_empty_flag_n, 1'b1);
      chk(o_almost_empty_n, 1'b1);
      repeat (3) get(mk[i]);
      chk(o_empty_flag_n, 1'b0);
      chk(o_almost_empty_n, 1'b0);
    end
    // fill past full, then drain with idle write edges
    mr(1'b1, 1'b1, `OUT_W36, 4'h2, 4'h2);
    repeat (17) begin
      put(1);
      chk(o_half_full_n, !(q.size() > 8));
      chk(o_full_flag_n, q.size() != 16);
      chk(o_almost_full_n, q.size() < 14);
    end
    while (q.size() > 0) begin
      get(`LANE36_MASK);
      peer.wr(1'b0, 36'h0);
      chk(o_half_full_n, !(q.size() > 8));
      chk(o_full_flag_n, 1'b1);
      chk(o_almost_full_n, q.size() < 14);
    end
    // normal-latency retransmit after a few words, far below depth minus two
    mr(1'b1, 1'b1, `OUT_W36, 4'h2, 4'h2);
    put(4);
    sv = q;
    get(`LANE36_MASK);
    peer.rd(1'b0, 1'b1);
    chk(o_empty_flag_n, 1'b0);
    q = sv;
    repeat (4) get(`LANE36_MASK);
    // zero-latency retransmit from empty, asynchronous almost flags
    mr(1'b0, 1'b0, `OUT_W36, 4'h2, 4'hD);
    put(3);
    chk(o_almost_full_n, 1'b0);
    chk(o_almost_empty_n, 1'b1);
    sv = q;
    get(`LANE36_MASK);
    chk(o_almost_full_n, 1'b1);
    chk(o_almost_empty_n, 1'b0);
    repeat (2) get(`LANE36_MASK);
    peer.rd(1'b0, 1'b1);
    chk(o_read_data_out, sv[0]);
    chk(o_empty_flag_n, 1'b1);
    q = sv;
    void'(q.pop_front());
    repeat (2) get(`LANE36_MASK);
    // fall-through: two-edge ready latency, one extra word of capacity, input-ready
    i_first_word_fall_through <= 1'b1;
    cap = 17;
    mr(1'b1, 1'b1, `OUT_W18, 4'h2, 4'h2);
    put(1);
    peer.rd(1'b0, 1'b0);
    chk(o_empty_flag_n, 1'b1);
    peer.rd(1'b0, 1'b0);
    chk(o_empty_flag_n, 1'b0);
    chk(o_read_data_out, q[0] & `LANE18_MASK);
    repeat (17) begin
      put(1);
      chk(o_half_full_n, !(q.size() > 9));
      chk(o_full_flag_n, q.size() == 17);
      chk(o_almost_full_n, q.size() < 15);
    end
    while (q.size() > 0) begin
      fget(`LANE18_MASK);
      peer.wr(1'b0, 36'h0);
      chk(o_full_flag_n, 1'b0);
      chk(o_half_full_n, !(q.size() > 9));
      chk(o_almost_full_n, q.size() < 15);
      chk(o_almost_empty_n, q.size() > 3);
    end
    // partial reset keeps fall-through, then normal-latency retransmit
    i_partial_reset_n <= 1'b0;
    repeat (5) @(posedge i_ref_clk);
    i_partial_reset_n <= 1'b1;
    repeat (5) @(posedge i_ref_clk);
    q.delete();
    put(3);
    sv = q;
    fget(`LANE18_MASK);
    peer.rd(1'b0, 1'b1);
    chk(o_empty_flag_n, 1'b1);
    q = sv;
    repeat (3) fget(`LANE18_MASK);
    results();
  end
endmodule
